// [inc/sld_pkg.sv]
// shared constants and types of the serial segment driver
`default_nettype none

package sld_pkg;

    localparam int          SEG_COUNT     = 35;
    localparam int          FRAME_CLOCKS  = 36;
    localparam int          PIN_COUNT     = 3;
    // index of the output that the enable variant gives up
    localparam int          SEG_EN_SLOT   = 34;

    localparam logic [5:0]  CNT_ZERO      = 6'h00;
    localparam logic [5:0]  CNT_ONE       = 6'h01;
    // rises seen before the 36th clock of a frame
    localparam logic [5:0]  CNT_LAST      = 6'h23;

    localparam logic [34:0] SEG_OFF       = 35'h0;

    // serial clock limit and the least period it allows
    localparam int          SCLK_MAX_KHZ  = 500;
    localparam int          CLK_KHZ       = 40000;
    localparam int          SCLK_MIN_CYC  =
        (CLK_KHZ + SCLK_MAX_KHZ - 1) / SCLK_MAX_KHZ;

    typedef enum logic [1:0] {
        SLD_IDLE  = 2'b00,
        SLD_SHIFT = 2'b01,
        SLD_LOAD  = 2'b10
    } sld_state_e;

    typedef struct packed {
        logic sclk;
        logic sdata;
        logic enable;
    } sld_pins_s;

endpackage

`default_nettype wire

// [verilog/sld_pin_filter.sv]
// three-stage synchroniser and agreement filter for the serial pins
`default_nettype none

module sld_pin_filter (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire sld_pkg::sld_pins_s pins_in,
    output var  sld_pkg::sld_pins_s pins_out
);

    logic [sld_pkg::PIN_COUNT-1:0] raw;
    logic [sld_pkg::PIN_COUNT-1:0] filt;

    assign raw      = pins_in;
    assign pins_out = filt;

    genvar g;
    generate
        for (g = 0; g < sld_pkg::PIN_COUNT; g = g + 1) begin : g_pin
            logic s1;
            logic s2;
            logic s3;
            logic lvl;
            logic next_lvl;

            // a level only counts once two later stages agree
            always_comb begin
                next_lvl = (s2 == s3) ? s3 : lvl;
            end

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    s1  <= 1'b0;
                    s2  <= 1'b0;
                    s3  <= 1'b0;
                    lvl <= 1'b0;
                end else begin
                    s1  <= raw[g];
                    s2  <= s1;
                    s3  <= s2;
                    lvl <= next_lvl;
                end
            end

            assign filt[g] = lvl;
        end
    endgenerate

endmodule

`default_nettype wire

// [verilog/sld_segment_driver.sv]
// serial-in latched segment driver: frame decode, shift stages, latches
`default_nettype none

module sld_segment_driver #(
    parameter bit ENABLE_VARIANT = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        serial_clk,
    input  wire logic        serial_data,
    input  wire logic        data_enable,
    output logic      [34:0] segment_on,
    output logic             load_pulse,
    output logic             clear_pulse
);

    sld_pkg::sld_pins_s  pins_raw;
    sld_pkg::sld_pins_s  pins;
    sld_pkg::sld_state_e state;
    sld_pkg::sld_state_e next_state;
    logic          [5:0] count;
    logic          [5:0] next_count;
    logic         [34:0] shreg;
    logic         [34:0] next_shreg;
    logic         [34:0] next_segment;
    logic                next_load;
    logic                next_clear;
    logic                sclk_q;
    logic                gate;
    logic                rise;
    logic                fall;
    logic         [34:0] shifted;
    logic         [34:0] mapped;

    assign pins_raw.sclk   = serial_clk;
    assign pins_raw.sdata  = serial_data;
    assign pins_raw.enable = data_enable;

    sld_pin_filter u_filter (
        .clk      (clk),
        .reset_n  (reset_n),
        .pins_in  (pins_raw),
        .pins_out (pins)
    );

    // a deselected driver sees no edges, so lines may be shared
    assign gate = !ENABLE_VARIANT || pins.enable;
    assign rise = gate && pins.sclk && !sclk_q;
    assign fall = gate && !pins.sclk && sclk_q;

    // the last data bit enters on the same edge that loads the latches
    assign shifted = {shreg[33:0], pins.sdata};

    genvar g;
    generate
        for (g = 0; g < sld_pkg::SEG_COUNT; g = g + 1) begin : g_map
            if (ENABLE_VARIANT && g == sld_pkg::SEG_EN_SLOT) begin : g_en
                assign mapped[g] = 1'b0;
            end else begin : g_seg
                // earliest bit sits deepest in the shift chain
                assign mapped[g] = shifted[sld_pkg::SEG_COUNT-1-g];
            end
        end
    endgenerate

    always_comb begin
        next_state   = state;
        next_count   = count;
        next_shreg   = shreg;
        next_segment = segment_on;
        next_load    = 1'b0;
        next_clear   = 1'b0;
        unique case (state)
            sld_pkg::SLD_IDLE: begin
                // zeros before a leading one are not a frame
                if (rise && pins.sdata) begin
                    next_state = sld_pkg::SLD_SHIFT;
                    next_count = sld_pkg::CNT_ONE;
                end
            end
            sld_pkg::SLD_SHIFT: begin
                if (rise) begin
                    next_shreg = shifted;
                    if (count == sld_pkg::CNT_LAST) begin
                        // latch bits follow the data: one is on
                        next_segment = mapped;
                        next_load    = 1'b1;
                        next_state   = sld_pkg::SLD_LOAD;
                    end else begin
                        next_count = count + sld_pkg::CNT_ONE;
                    end
                end
            end
            sld_pkg::SLD_LOAD: begin
                // a short frame never reaches here and stays uncleared
                if (fall) begin
                    next_shreg = sld_pkg::SEG_OFF;
                    next_count = sld_pkg::CNT_ZERO;
                    next_clear = 1'b1;
                    // start capture is untouched, next rise may start
                    next_state = sld_pkg::SLD_IDLE;
                end
            end
            default: begin
                next_state = sld_pkg::SLD_IDLE;
                next_count = sld_pkg::CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state       <= sld_pkg::SLD_IDLE;
            count       <= sld_pkg::CNT_ZERO;
            shreg       <= sld_pkg::SEG_OFF;
            segment_on  <= sld_pkg::SEG_OFF;
            load_pulse  <= 1'b0;
            clear_pulse <= 1'b0;
            sclk_q      <= 1'b0;
        end else begin
            state       <= next_state;
            count       <= next_count;
            shreg       <= next_shreg;
            segment_on  <= next_segment;
            load_pulse  <= next_load;
            clear_pulse <= next_clear;
            sclk_q      <= pins.sclk;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_load_on_last: assert property (
        (state == sld_pkg::SLD_SHIFT && rise && count == sld_pkg::CNT_LAST)
        |=> load_pulse && state == sld_pkg::SLD_LOAD)
        else $error("latch load missed on 36th clock");

    a_clear_on_fall: assert property (
        (state == sld_pkg::SLD_LOAD && fall)
        |=> clear_pulse && shreg == sld_pkg::SEG_OFF
            && count == sld_pkg::CNT_ZERO)
        else $error("shift stages not cleared in low phase");

    a_clear_after_load: assert property (
        clear_pulse |-> state == sld_pkg::SLD_IDLE
            && $past(state) == sld_pkg::SLD_LOAD)
        else $error("clear came without a preceding load");

    a_start_capture: assert property (
        (state == sld_pkg::SLD_IDLE && rise && pins.sdata)
        |=> state == sld_pkg::SLD_SHIFT && count == sld_pkg::CNT_ONE)
        else $error("leading one did not start a frame");

    a_first_bit_map: assert property (
        load_pulse |-> segment_on[0] == $past(shreg[33]))
        else $error("first data bit not on output one");

    a_latch_hold: assert property (
        !load_pulse |-> $stable(segment_on))
        else $error("outputs changed without a load");

    a_reset_off: assert property (
        @(posedge clk) disable iff (1'b0)
        !reset_n |-> segment_on == sld_pkg::SEG_OFF
            && shreg == sld_pkg::SEG_OFF)
        else $error("reset left a stage or latch set");

    a_enable_slot: assert property (
        ENABLE_VARIANT |-> !segment_on[sld_pkg::SEG_EN_SLOT])
        else $error("enable slot drove an output");

    a_disabled_ignored: assert property (
        (ENABLE_VARIANT && !pins.enable)
        |=> $stable(count) && $stable(shreg) && $stable(state))
        else $error("clock acted while enable was low");

    a_frame_count: assert property (
        state == sld_pkg::SLD_SHIFT
        |-> count >= sld_pkg::CNT_ONE && count <= sld_pkg::CNT_LAST)
        else $error("frame bit count out of range");

endmodule

`default_nettype wire

// [verification/sld_host_model.sv]
// host-side model that shifts frames into the segment driver pins
`default_nettype none

module sld_host_model (
    input  wire logic clk,
    output var  logic serial_clk,
    output var  logic serial_data,
    output var  logic data_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    // half of the shortest legal serial period, never faster than 0.5 MHz
    localparam int HALF = sld_pkg::SCLK_MIN_CYC / 2;

    initial begin
        serial_clk  = 1'b0;
        serial_data = 1'b0;
        data_enable = 1'b1;
    end

    // data set in the low phase and held through the high phase
    task automatic shift_bit(input logic b);
        @(negedge clk);
        serial_data = b;
        repeat (HALF) @(negedge clk);
        serial_clk = 1'b1;
        repeat (HALF) @(negedge clk);
        serial_clk = 1'b0;
    endtask

    // always a whole frame: start bit then 35 data bits, bit 1 first
    task automatic send_frame(input logic [34:0] seg, input logic en);
        // one edge apart from the previous frame's release of the lines
        @(negedge clk);
        data_enable = en;
        shift_bit(1'b1);
        for (int i = 0; i < sld_pkg::SEG_COUNT; i++) begin
            shift_bit(seg[i]);
        end
        // line left floating: show the inverse rather than the last bit
        @(negedge clk);
        serial_data = ~serial_data;
        data_enable = 1'b1;
    endtask
endmodule

`default_nettype wire

// [verification/serial_led_segment_driver_tb.sv]
// self-checking bench for both variants of the segment driver
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module serial_led_segment_driver_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // clock starts high so reset falls where the flops can see it
    logic        clk = 1'b1;
    logic        reset_n = 1'b1;
    logic        serial_clk;
    logic        serial_data;
    logic        data_enable;
    logic [34:0] seg_base;
    logic [34:0] seg_en;
    logic        load_base;
    logic        clear_base;
    logic        load_en;
    logic        clear_en;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          n_load = 0;
    int          n_clear = 0;
    int          n_load_en = 0;
    int          n_clear_en = 0;
    logic [34:0] pat_a = 35'h5_A5C3_0F01;

    always #12.5 clk = ~clk;

    sld_host_model u_sld_host_model (.clk(clk), .serial_clk(serial_clk),
        .serial_data(serial_data), .data_enable(data_enable));

    sld_segment_driver #(.ENABLE_VARIANT(1'b0)) u_sld_segment_driver (
        .clk(clk), .reset_n(reset_n), .serial_clk(serial_clk),
        .serial_data(serial_data), .data_enable(data_enable),
        .segment_on(seg_base), .load_pulse(load_base),
        .clear_pulse(clear_base));

    // second instance: enable variant on the same shared lines
    sld_segment_driver #(.ENABLE_VARIANT(1'b1)) u_sld_segment_driver_en (
        .clk(clk), .reset_n(reset_n), .serial_clk(serial_clk),
        .serial_data(serial_data), .data_enable(data_enable),
        .segment_on(seg_en), .load_pulse(load_en), .clear_pulse(clear_en));

    // pulses are counted away from the edge that launches them
    always @(negedge clk) begin
        if (load_base === 1'b1) n_load++;
        if (clear_base === 1'b1) n_clear++;
        if (load_en === 1'b1) n_load_en++;
        if (clear_en === 1'b1) n_clear_en++;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // six frames of about 2900 cycles each fit well below this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 25000) begin
            n_errors++;
            conclude();
        end
    end

    // settle past the pin filter and the clear after the last fall
    task automatic look(input logic [34:0] eb, input logic [34:0] ee);
        repeat (20) @(negedge clk);
        `CHK(seg_base, eb)
        `CHK(seg_en, ee & ~(35'h1 << sld_pkg::SEG_EN_SLOT))
    endtask

    task automatic test_reset();
        repeat (10) @(negedge clk);
        `CHK(seg_base, sld_pkg::SEG_OFF)
        `CHK(seg_en, sld_pkg::SEG_OFF)
    endtask

    task automatic test_single();
        u_sld_host_model.send_frame(pat_a, 1'b1);
        look(pat_a, pat_a);
        `CHK(n_load, 1)
        `CHK(n_clear, 1)
        `CHK(n_load_en, 1)
        `CHK(n_clear_en, 1)
    endtask

    task automatic test_back_to_back();
        u_sld_host_model.send_frame(~pat_a, 1'b1);
        u_sld_host_model.send_frame(pat_a ^ 35'h1_0000_0003, 1'b1);
        look(pat_a ^ 35'h1_0000_0003, pat_a ^ 35'h1_0000_0003);
        `CHK(n_load, 3)
        `CHK(n_clear, 3)
        `CHK(n_load_en, 3)
    endtask

    task automatic test_enable_low();
        u_sld_host_model.send_frame(35'h7_0F0F_F0F0, 1'b0);
        look(35'h7_0F0F_F0F0, pat_a ^ 35'h1_0000_0003);
        `CHK(n_load, 4)
        `CHK(n_load_en, 3)
    endtask

    // zeros before the start bit must not open a frame
    task automatic test_start_detect();
        repeat (3) u_sld_host_model.shift_bit(1'b0);
        u_sld_host_model.send_frame(35'h7_FFFF_FFFF, 1'b1);
        look(35'h7_FFFF_FFFF, 35'h7_FFFF_FFFF);
        `CHK(n_load, 5)
        `CHK(n_load_en, 4)
    endtask

    // a reset in mid-run clears everything, then a fresh frame is taken
    task automatic test_mid_reset();
        @(negedge clk);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        test_reset();
        u_sld_host_model.send_frame(pat_a, 1'b1);
        look(pat_a, pat_a);
        `CHK(n_load, 6)
        `CHK(n_load_en, 5)
    endtask

    initial begin
        @(negedge clk);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        test_reset();
        test_single();
        test_back_to_back();
        test_enable_low();
        test_start_detect();
        test_mid_reset();
        conclude();
    end
endmodule

`undef CHK
`default_nettype wire
